/* File: include/pcd_pkg.sv */
// Constants for the sparse I/O and configuration window decoder.
// Assumes a 40-bit processor physical address and a 32-bit PCI bus.
package pcd_pkg;

   // Processor address width
   localparam int unsigned ADDR_W = 40;

   // Sparse I/O window 85.8000.0000 .. 85.80FF.FFFF, split into fields
   localparam logic [4:0] IO_TOP_TAG   = 5'h10;  // Bits 39:35
   localparam logic [4:0] IO_SPARSE_TAG = 5'h16; // Bits 34:30, pattern 10110
   localparam logic [5:0] IO_LOW32_TAG = 6'h00;  // Bits 29:24, lowest 16 MB only

   // Configuration window 87.0000.0000 .. 87.1FFF.FFFF, bits 39:29
   localparam logic [10:0] CFG_WIN_TAG = 11'h438;

   // PCI bus commands
   localparam logic [3:0] CMD_IO_RD  = 4'h2;
   localparam logic [3:0] CMD_IO_WR  = 4'h3;
   localparam logic [3:0] CMD_CFG_RD = 4'hA;
   localparam logic [3:0] CMD_CFG_WR = 4'hB;

   // Configuration type field values
   localparam logic [1:0] CFG_TYPE0 = 2'h0;
   localparam logic [1:0] CFG_TYPE1 = 2'h1;

   // Sparse length codes in address bits 4:3
   localparam logic [3:0] LEN_MASK_BYTE = 4'h1;
   localparam logic [3:0] LEN_MASK_WORD = 4'h3;
   localparam logic [3:0] LEN_MASK_TRI  = 4'h7;
   localparam logic [3:0] LEN_MASK_LW   = 4'hF;

   // Data returned when no target claims the cycle
   localparam logic [31:0] NO_TARGET_DATA = 32'hFFFFFFFF;

   // Master abort timing
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned MABORT_NS     = 64;
   // Least time, so round up
   localparam int unsigned MABORT_CYC    = (MABORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  MABORT_LAST   = 4'(MABORT_CYC - 1);

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_DATA = 4'h4,
      ST_DONE = 4'h8
   } pcd_state_t;

endpackage

/* File: include/pcd_dec_if.sv */
// Carrier between the sequencer and the window decoder.
// Both ends run on the same clock; the decoder is purely combinational.
`timescale 1ns/1ns
interface pcd_dec_if;
   logic [39:0] addr;      // Processor physical address
   logic        write;     // Write request
   logic [1:0]  cfg_type;  // Configuration type field
   logic        hit_io;    // Sparse I/O window hit
   logic        hit_cfg;   // Configuration window hit
   logic [3:0]  cmd;       // PCI command for the hit
   logic [31:0] pci_addr;  // Address phase value
   logic [3:0]  cbe_n;     // Data phase byte enables, low active

   modport map (input addr, write, cfg_type, output hit_io, hit_cfg, cmd, pci_addr, cbe_n);
   modport seq (output addr, write, cfg_type, input hit_io, hit_cfg, cmd, pci_addr, cbe_n);
endinterface

/* File: src/pcd_addr_map.sv */
// Window decode and sparse address translation.
// Assumes its inputs are stable for the cycle in which the sequencer samples them.
`timescale 1ns/1ns
module pcd_addr_map (
   // Decode carrier
   pcd_dec_if.map dec
);

   // Address fields
   wire [4:0]  top_bits    = dec.addr[39:35];  // Unused for cycle typing
   wire [4:0]  sparse_bits = dec.addr[34:30];
   wire [5:0]  low32_bits  = dec.addr[29:24];
   wire [1:0]  byte_offs   = dec.addr[6:5];
   wire [1:0]  len_code    = dec.addr[4:3];
   // Reserved type codes 10 and 11 are never loaded; only bit 0 is looked at
   wire        type1       = dec.cfg_type[0];
   wire [3:0]  len_mask;                      // Lanes before shifting
   wire [7:0]  be_wide;                       // Shifted lanes, top half dropped

   // Positive decode: claim comes only from the processor address
   assign dec.hit_io  = (top_bits == pcd_pkg::IO_TOP_TAG)
                      && (sparse_bits == pcd_pkg::IO_SPARSE_TAG)
                      && (low32_bits == pcd_pkg::IO_LOW32_TAG);
   assign dec.hit_cfg = (dec.addr[39:29] == pcd_pkg::CFG_WIN_TAG);

   // Command from window and direction
   assign dec.cmd = dec.hit_cfg ? (dec.write ? pcd_pkg::CMD_CFG_WR : pcd_pkg::CMD_CFG_RD)
                                : (dec.write ? pcd_pkg::CMD_IO_WR : pcd_pkg::CMD_IO_RD);

   // Sparse length to lane mask
   assign len_mask = (len_code == 2'h0) ? pcd_pkg::LEN_MASK_BYTE :
                     (len_code == 2'h1) ? pcd_pkg::LEN_MASK_WORD :
                     (len_code == 2'h2) ? pcd_pkg::LEN_MASK_TRI  : pcd_pkg::LEN_MASK_LW;
   assign be_wide   = {4'h0, len_mask} << byte_offs;
   assign dec.cbe_n = ~be_wide[3:0];

   // Address phase: quadword from bits 30:8, low bits from 7:5 or the type field
   assign dec.pci_addr[31:26] = 6'h00;
   assign dec.pci_addr[25]    = dec.hit_cfg & dec.addr[30];
   assign dec.pci_addr[24:3]  = dec.addr[29:8];
   assign dec.pci_addr[2]     = dec.addr[7];
   // Type bits come from the field, never from address bits 38:35
   assign dec.pci_addr[1:0]   = dec.hit_cfg ? (type1 ? pcd_pkg::CFG_TYPE1 : pcd_pkg::CFG_TYPE0)
                                            : dec.addr[6:5];

endmodule

/* File: src/pcd_decoder.sv */
// Sparse I/O and configuration window bridge toward the PCI bus.
// Assumes one processor request at a time and a bus that is always granted.
//
// Overview of operation
// - I/O window accesses become PCI I/O cycles
// - Address bits 34:30 equal 10110 select I/O
// - PCI address bits 31:25 zero for I/O
// - I/O window claimed by positive decoding
// - Configuration window accesses become configuration cycles
// - Type field 00 gives Type 0, 01 Type 1
// - Configuration accesses use sparse size encoding
// - Type field replaces address bits 38:35 (here it gives PCI address bits 1:0 in place of bits 6:5)
// - Bits 7:3 give byte enables, low address
// - Bits 30:8 go out as quadword address
`timescale 1ns/1ns
module pcd_decoder (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   // Processor request side
   input  wire logic        CPU_REQ_I,
   input  wire logic        CPU_WE_I,
   input  wire logic [39:0] CPU_ADDR_I,
   input  wire logic [31:0] CPU_WDATA_I,
   output logic             CPU_READY_O,
   output logic             CPU_ACK_O,
   output logic             CPU_MISS_O,
   output logic             CPU_ABORT_O,
   output logic [31:0]      CPU_RDATA_O,
   // Configuration type field
   input  wire logic [1:0]  CFG_TYPE_I,
   // PCI pins
   input  wire logic [31:0] PCI_AD_I,
   output logic [31:0]      PCI_AD_O,
   output logic             PCI_AD_OE_N_O,
   output logic [3:0]       PCI_CBE_N_O,
   output logic             PCI_CBE_OE_N_O,
   output logic             PCI_FRAME_N_O,
   output logic             PCI_IRDY_N_O,
   output logic             PCI_CTL_OE_N_O,
   input  wire logic        PCI_DEVSEL_N_I,
   input  wire logic        PCI_TRDY_N_I
);

   // Decoder carrier and instance
   pcd_dec_if dec ();

   pcd_addr_map u_map (
      .dec (dec.map)
   );

   // State and request latches
   pcd_pkg::pcd_state_t state_reg;   // Sequencer state
   pcd_pkg::pcd_state_t state_next;  // Next state
   logic [31:0] addr_reg;            // Address phase value
   logic [3:0]  cmd_reg;             // Latched command
   logic [3:0]  cbe_n_reg;           // Latched byte enables
   logic        we_reg;              // Latched direction
   logic [31:0] wdata_reg;           // Latched write data
   logic [31:0] rdata_reg;           // Returned read data
   logic        abort_reg;           // Last cycle master aborted
   logic        miss_reg;            // Miss answer pulse
   logic [3:0]  wait_reg;            // Data phase wait count

   // Pin synchronisers, first stage read only by second
   logic        devsel_n_s1_reg;
   logic        devsel_n_s2_reg;
   logic        trdy_n_s1_reg;
   logic        trdy_n_s2_reg;
   logic [31:0] ad_s1_reg;
   logic [31:0] ad_s2_reg;

   // Feed the decoder straight from the request port
   assign dec.addr     = CPU_ADDR_I;
   assign dec.write    = CPU_WE_I;
   // Field is assumed set before the access is made
   assign dec.cfg_type = CFG_TYPE_I;

   // Named decode terms
   wire st_idle   = (state_reg == pcd_pkg::ST_IDLE);
   wire st_addr   = (state_reg == pcd_pkg::ST_ADDR);
   wire st_data   = (state_reg == pcd_pkg::ST_DATA);
   wire st_done   = (state_reg == pcd_pkg::ST_DONE);
   wire win_hit   = dec.hit_io | dec.hit_cfg;
   wire take_hit  = st_idle & CPU_REQ_I & win_hit;
   wire take_miss = st_idle & CPU_REQ_I & ~win_hit;
   wire claimed   = ~devsel_n_s2_reg & ~trdy_n_s2_reg;
   // Count bounds the wait so an absent target cannot stall the processor
   wire timeout   = (wait_reg == pcd_pkg::MABORT_LAST);

   // Two-flop synchronisers on the PCI inputs
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         devsel_n_s1_reg <= 1'b1;
         devsel_n_s2_reg <= 1'b1;
         trdy_n_s1_reg   <= 1'b1;
         trdy_n_s2_reg   <= 1'b1;
         ad_s1_reg       <= 32'h00000000;
         ad_s2_reg       <= 32'h00000000;
      end else begin
         devsel_n_s1_reg <= PCI_DEVSEL_N_I;
         devsel_n_s2_reg <= devsel_n_s1_reg;
         trdy_n_s1_reg   <= PCI_TRDY_N_I;
         trdy_n_s2_reg   <= trdy_n_s1_reg;
         ad_s1_reg       <= PCI_AD_I;
         ad_s2_reg       <= ad_s1_reg;
      end
   end

   // Next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         // Wait for a window hit
         pcd_pkg::ST_IDLE: begin
            if (take_hit) begin
               state_next = pcd_pkg::ST_ADDR;
            end
         end
         // One address phase
         pcd_pkg::ST_ADDR: begin
            state_next = pcd_pkg::ST_DATA;
         end
         // Single data phase, ended by target or timeout
         pcd_pkg::ST_DATA: begin
            if (claimed || timeout) begin
               state_next = pcd_pkg::ST_DONE;
            end
         end
         // Answer and turn the bus round
         pcd_pkg::ST_DONE: begin
            state_next = pcd_pkg::ST_IDLE;
         end
         // Illegal one-hot code recovers to idle
         default: begin
            state_next = pcd_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg <= pcd_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Latch the translated request when it is taken
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         addr_reg  <= 32'h00000000;
         cmd_reg   <= 4'h0;
         cbe_n_reg <= 4'hF;
         we_reg    <= 1'b0;
         wdata_reg <= 32'h00000000;
      end else if (take_hit) begin
         addr_reg  <= dec.pci_addr;
         cmd_reg   <= dec.cmd;
         cbe_n_reg <= dec.cbe_n;
         we_reg    <= CPU_WE_I;
         wdata_reg <= CPU_WDATA_I;
      end
   end

   // Data phase wait counter
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wait_reg <= 4'h0;
      end else if (st_data) begin
         wait_reg <= wait_reg + 4'h1;
      end else begin
         wait_reg <= 4'h0;
      end
   end

   // Read data and abort status
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_reg <= 32'h00000000;
         abort_reg <= 1'b0;
      end else if (st_data && claimed) begin
         // Target answered
         rdata_reg <= we_reg ? 32'h00000000 : ad_s2_reg;
         abort_reg <= 1'b0;
      end else if (st_data && timeout) begin
         // Nobody claimed: raise the abort flag and return all ones
         rdata_reg <= pcd_pkg::NO_TARGET_DATA;
         abort_reg <= 1'b1;
      end
   end

   // Miss answer, one cycle after an out-of-window request
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         miss_reg <= 1'b0;
      end else begin
         miss_reg <= take_miss;
      end
   end

   // Processor answers
   assign CPU_READY_O = st_idle & ~miss_reg;
   assign CPU_ACK_O   = st_done | miss_reg;
   assign CPU_MISS_O  = miss_reg;
   assign CPU_ABORT_O = abort_reg;
   assign CPU_RDATA_O = rdata_reg;

   // PCI pin drive; enables low while driving
   assign PCI_AD_O       = st_addr ? addr_reg : wdata_reg;
   assign PCI_AD_OE_N_O  = ~(st_addr | (st_data & we_reg));
   assign PCI_CBE_N_O    = st_addr ? cmd_reg : cbe_n_reg;
   assign PCI_CBE_OE_N_O = ~(st_addr | st_data);
   assign PCI_FRAME_N_O  = ~st_addr;
   assign PCI_IRDY_N_O   = ~st_data;
   // Control lines held deasserted one cycle before release
   assign PCI_CTL_OE_N_O = ~(st_addr | st_data | st_done);

endmodule

/* File: test/pcd_decoder_sva.sv */
// Checker for the window decoder, watching the top ports only.
// Assumes one clock domain and the low active asynchronous reset.
`timescale 1ns/1ns
module pcd_decoder_sva (
   // Clock and reset
   input wire logic        SYS_CLK_I,
   input wire logic        RST_N_I,
   // Processor side
   input wire logic        CPU_REQ_I,
   input wire logic        CPU_WE_I,
   input wire logic [39:0] CPU_ADDR_I,
   input wire logic [1:0]  CFG_TYPE_I,
   input wire logic        CPU_READY_O,
   input wire logic        CPU_ACK_O,
   input wire logic        CPU_MISS_O,
   // PCI side
   input wire logic [31:0] PCI_AD_O,
   input wire logic [3:0]  PCI_CBE_N_O,
   input wire logic        PCI_FRAME_N_O,
   input wire logic        PCI_IRDY_N_O,
   input wire logic        PCI_AD_OE_N_O,
   input wire logic        PCI_CBE_OE_N_O,
   input wire logic        PCI_CTL_OE_N_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Window hits, decoded here apart from the design
   wire io_w  = CPU_ADDR_I[39:24] == 16'h8580;
   wire cfg_w = CPU_ADDR_I[39:29] == 11'h438;
   wire take  = CPU_REQ_I && CPU_READY_O;

   chk_io_cmd: assert property (take && io_w |=> !PCI_FRAME_N_O && PCI_CBE_N_O == {3'h1, $past(CPU_WE_I)})
      else $error("io command wrong");
   chk_io_addr: assert property (take && io_w |=> PCI_AD_O == {7'h00, $past(CPU_ADDR_I[29:5])})
      else $error("io address phase wrong");
   chk_cfg_cmd: assert property (take && cfg_w |=> PCI_CBE_N_O == {3'h5, $past(CPU_WE_I)})
      else $error("config command wrong");
   chk_cfg_addr: assert property (take && cfg_w |=>
      PCI_AD_O == {6'h00, $past(CPU_ADDR_I[30:7]), 1'h0, $past(CFG_TYPE_I[0])})
      else $error("config address phase wrong");
   chk_miss_quiet: assert property (take && !io_w && !cfg_w |=> CPU_MISS_O && CPU_ACK_O && PCI_FRAME_N_O)
      else $error("miss not answered quietly");
   chk_hit_bound: assert property (take && (io_w || cfg_w) |-> ##[3:10] (CPU_ACK_O && !CPU_MISS_O))
      else $error("hit not answered in time");
   chk_frame_once: assert property ($fell(PCI_FRAME_N_O) |=> PCI_FRAME_N_O && !PCI_IRDY_N_O)
      else $error("address phase not one cycle");
   chk_ack_pulse: assert property (CPU_ACK_O |=> !CPU_ACK_O)
      else $error("answer longer than a cycle");
   chk_miss_ack: assert property (CPU_MISS_O |-> CPU_ACK_O)
      else $error("miss without answer");
   chk_miss_busy: assert property (CPU_MISS_O |-> !CPU_READY_O)
      else $error("ready during miss answer");
   chk_addr_drive: assert property (!PCI_FRAME_N_O |-> !PCI_AD_OE_N_O && !PCI_CBE_OE_N_O && !PCI_CTL_OE_N_O)
      else $error("address phase not driven");
   chk_data_drive: assert property (!PCI_IRDY_N_O |-> !PCI_CBE_OE_N_O && !PCI_CTL_OE_N_O)
      else $error("data phase enables not driven");
   chk_bus_release: assert property (CPU_ACK_O |=> PCI_AD_OE_N_O && PCI_CBE_OE_N_O && PCI_CTL_OE_N_O)
      else $error("bus not released after answer");

   // Main scenarios reached
   cov_io: cover property (take && io_w);
   cov_cfg: cover property (take && cfg_w);
   cov_miss: cover property (CPU_MISS_O);
endmodule

bind pcd_decoder pcd_decoder_sva pcd_decoder_sva_i (.SYS_CLK_I, .RST_N_I, .CPU_REQ_I, .CPU_WE_I, .CPU_ADDR_I,
   .CFG_TYPE_I, .CPU_READY_O, .CPU_ACK_O, .CPU_MISS_O, .PCI_AD_O, .PCI_CBE_N_O, .PCI_FRAME_N_O, .PCI_IRDY_N_O,
   .PCI_AD_OE_N_O, .PCI_CBE_OE_N_O, .PCI_CTL_OE_N_O);

/* File: test/pcd_pci_tgt_model.sv */
// PCI target model: claims after a set delay, or stays absent.
// Assumes one data phase per frame; released lines pull high or invert.
`timescale 1ns/1ns
module pcd_pci_tgt_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Bus as driven by the master
   input  wire logic        frame_n_i,
   input  wire logic        irdy_n_i,
   input  wire logic [31:0] ad_i,
   input  wire logic [3:0]  cbe_n_i,
   // Behaviour set by the bench
   input  wire logic        respond_i,
   input  wire logic [3:0]  delay_i,
   input  wire logic [31:0] rdata_i,
   // Target drive and capture
   output logic [31:0]      ad_o,
   output logic             devsel_n_o,
   output logic             trdy_n_o,
   output logic [31:0]      cap_ad_o,
   output logic [3:0]       cap_be_o,
   output logic [7:0]       frames_o
);
   logic [3:0] cnt; // Data phase cycles seen

   // Claim once the delay runs out; absent target never claims
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {devsel_n_o, trdy_n_o} <= 2'h3;
         {ad_o, cap_ad_o, cap_be_o, frames_o, cnt} <= '0;
      end else begin
         if (!frame_n_i) begin
            frames_o <= frames_o + 8'h01;
            cnt      <= 4'h0;
         end else if (!irdy_n_i) begin
            cnt <= cnt + 4'h1;
         end
         if (!irdy_n_i && respond_i && cnt >= delay_i) begin
            {devsel_n_o, trdy_n_o} <= 2'h0;
            ad_o     <= rdata_i;
            cap_ad_o <= ad_i;
            cap_be_o <= cbe_n_i;
         end else begin
            // Pull-ups take the controls; data shows no stale value
            {devsel_n_o, trdy_n_o} <= 2'h3;
            ad_o <= ~ad_o;
         end
      end
   end
endmodule

/* File: test/pcd_decoder_tb_top.sv */
// Self-checking bench for the window decoder with one PCI target.
// Assumes the checker is bound in and the bus is always granted.
`timescale 1ns/1ns
module pcd_decoder_tb_top;
   logic clk, rst_n, req, we, ready, ack, miss, abort, respond, ad_oe_n, frame_n, irdy_n, devsel_n, trdy_n;
   logic [39:0] addr;
   logic [31:0] wdata, rdata, rdata_m, ad_o, tgt_ad, cap_ad;
   logic [3:0]  cbe_n, cap_be, delay;
   logic [1:0]  cfg_type;
   logic [7:0]  frames;
   int mismatches, tests_run;
   logic [39:0] miss_tab [3] = '{40'h85_8100_0000, 40'h87_2000_0000, 40'h85_7FFF_FFF8};

   pcd_decoder pcd_decoder_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CPU_REQ_I(req), .CPU_WE_I(we), .CPU_ADDR_I(addr),
      .CPU_WDATA_I(wdata), .CPU_READY_O(ready), .CPU_ACK_O(ack), .CPU_MISS_O(miss), .CPU_ABORT_O(abort),
      .CPU_RDATA_O(rdata), .CFG_TYPE_I(cfg_type), .PCI_AD_I(ad_oe_n ? tgt_ad : ad_o), .PCI_AD_O(ad_o),
      .PCI_AD_OE_N_O(ad_oe_n), .PCI_CBE_N_O(cbe_n), .PCI_CBE_OE_N_O(), .PCI_FRAME_N_O(frame_n),
      .PCI_IRDY_N_O(irdy_n), .PCI_CTL_OE_N_O(), .PCI_DEVSEL_N_I(devsel_n), .PCI_TRDY_N_I(trdy_n));
   pcd_pci_tgt_model pcd_pci_tgt_model_i (.clk_i(clk), .rst_n_i(rst_n), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
      .ad_i(ad_o), .cbe_n_i(cbe_n), .respond_i(respond), .delay_i(delay), .rdata_i(rdata_m), .ad_o(tgt_ad),
      .devsel_n_o(devsel_n), .trdy_n_o(trdy_n), .cap_ad_o(cap_ad), .cap_be_o(cap_be), .frames_o(frames));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Low active lanes from length code and byte offset
   function automatic logic [3:0] exp_be(input logic [39:0] a);
      logic [7:0] m;
      m = ((8'h02 << a[4:3]) - 8'h01) << a[6:5];
      return ~m[3:0];
   endfunction

   task automatic chk1(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // One request, held for one clock edge, answer sampled mid-cycle
   task automatic cpu_op(input logic [39:0] a, input logic w, input logic [31:0] d,
                         output logic m, output logic ab, output logic [31:0] rd);
      int n;
      req   <= 1'b1;
      we    <= w;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      // A lost answer ends the run
      if (n >= 20) begin
         mismatches++;
         end_sim();
      end
      {m, ab, rd} = {miss, abort, rdata};
      @(posedge clk);
   endtask

   initial begin
      logic [39:0] a;
      logic [31:0] d, rd;
      logic        w, m, ab, r;
      logic [7:0]  f;
      {rst_n, req, we, addr, wdata, cfg_type, delay, rdata_m} = '0;
      respond    = 1'b1;
      mismatches = 0;
      tests_run  = 0;
      void'($urandom(68937));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk1("idle_frame_n", 1'b1, frame_n);
      @(posedge clk);
      // I/O then config, both directions, prompt, slow and absent targets
      for (int i = 0; i < 32; i++) begin
         w = i[0];
         r = !(i[4] & i[3] & i[2]);
         a = i[4] ? {11'h438, 29'($urandom)} : {16'h8580, 24'($urandom)};
         a[4:3] = 2'(i >> 2);
         d = $urandom;
         respond  <= r;
         delay    <= i[1] ? 4'h2 : 4'h0;
         rdata_m  <= d;
         cfg_type <= {1'b0, i[1]};
         cpu_op(a, w, d, m, ab, rd);
         chk1("miss", 1'b0, m);
         if (!r) begin
            chk1("abort_set", 1'b1, ab);
            if (!w) chk32("abort_data", 32'hFFFFFFFF, rd);
         end else begin
            chk1("abort_clear", 1'b0, ab);
            chk32("byte_en", {28'h0, exp_be(a)}, {28'h0, cap_be});
            if (w) begin
               chk32("wr_data", d, cap_ad);
               chk32("wr_rdata", 32'h00000000, rd);
            end else begin
               chk32("rd_data", d, rd);
            end
         end
      end
      $display("test windows done");
      // Addresses just outside the windows start no cycle
      for (int i = 0; i < 3; i++) begin
         f = frames;
         cpu_op(miss_tab[i], 1'b0, 32'h0, m, ab, rd);
         chk1("miss", 1'b1, m);
         chk32("frames", {24'h0, f}, {24'h0, frames});
      end
      $display("test outside done");
      end_sim();
   end
endmodule
